/* File: hw/mgmt_frame_slave.sv */
// Management serial slave: frame decoder, register pages and interrupt pin.
// Assumes the station clocks mdc and gives idle ones before the first frame.
//
// Overview of operation
// - Sample data line on rising clock edge
// - Launch read bits on rising clock edge
// - Manager clocks up to 12.5 MHz, may stop
// - Transactions use 32-bit frames, optional preamble
// - Manager gives two idle ones before first frame
// - Line undriven while idle
// - One or more ones form a preamble
// - Start pattern 01, else skip frame
// - Opcode 10 read, 01 write, else skip
// - Act only when address matches own
// - Next five bits select the register
// - Drive zero on second turnaround bit
// - Read data held rising edge to edge
// - Manager holds write data around rising edge
// - 32 registers, pages selected via register 31
// - Indirect extended access through registers 13, 14
// - Interrupt pin gated by register 25 bit 15
// - Interrupt drives only its asserted level
`timescale 1ns/100ps
`include "mgmt_serial_params.svh"
module mgmt_frame_slave
(
	// Link
	mgmt_serial_if.device link,
	// System clock and control
	input logic ref_clk,
	input logic rst_n,
	input logic clk_en,
	// Straps
	input logic [4:0] phy_addr,
	input logic int_active_high,
	// Events and write notification
	input logic phy_event,
	output logic wr_valid,
	output logic [4:0] wr_reg,
	output logic [15:0] wr_data,
	// Interrupt pin
	output logic mgmt_interrupt_out_o,
	output logic mgmt_interrupt_out_oe
);
	function automatic logic [4:0] skip_from(input int done);
		return 5'(`MGMT_FRAME_BITS - done - 1);
	endfunction

	// Link domain: reset, enable, address and pending flag cross in
	logic rst_m_n;
	logic en_m;
	logic [4:0] addr_m;
	logic pend_m;
	logic pend_q;
	// Reset request stays up until the link side has seen it, since mdc may stand still during rst_n
	logic rst_req_q;
	mgmt_sync2 #(.W(8)) u_sync_in
	(
		.clk(link.mdc),
		.d({!rst_req_q, clk_en, phy_addr, pend_q}),
		.q({rst_m_n, en_m, addr_m, pend_m})
	);

	mgmt_serial_pkg::dev_state_t st_q, st_d;
	logic [4:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic rd_q, rd_d;
	logic [4:0] reg_q, reg_d;
	logic out_q, out_d;
	logic oe_q, oe_d;
	logic [15:0] sh_in;
	logic do_read;
	logic do_write;
	mgmt_serial_pkg::reg_word_t rd_word;

	mgmt_serial_pkg::reg_word_t std_q [0:`MGMT_REG_COUNT-1];
	mgmt_serial_pkg::reg_word_t ext_q [0:`MGMT_REG_COUNT-1];
	mgmt_serial_pkg::reg_word_t mmd_q [0:`MGMT_MMD_DEPTH-1];
	mgmt_serial_pkg::reg_word_t page_q, page_d;
	mgmt_serial_pkg::reg_word_t mmd_ctl_q, mmd_ctl_d;
	mgmt_serial_pkg::reg_word_t mmd_addr_q, mmd_addr_d;
	logic std_we, ext_we, mmd_we;
	logic clr_tgl_q, clr_tgl_d;
	logic wr_tgl_q, wr_tgl_d;
	logic [4:0] wr_addr_q, wr_addr_d;
	logic [15:0] wr_val_q, wr_val_d;

	assign sh_in = {sh_q[14:0], link.mdio};
	assign link.dev_mdio_o = out_q;
	assign link.dev_mdio_oe = oe_q;

	// Read mux, addressed by the register field as it completes
	always_comb
	begin
		rd_word = `MGMT_REG_RESET;
		if (sh_in[4:0] == `MGMT_PAGE_REG)
			rd_word = page_q;
		else if (sh_in[4:0] == `MGMT_MMD_CTRL_REG)
			rd_word = mmd_ctl_q;
		else if (sh_in[4:0] == `MGMT_MMD_DATA_REG)
			rd_word = (mmd_ctl_q[15:14] == `MGMT_MMD_FUNC_ADDR) ? mmd_addr_q : mmd_q[mmd_addr_q[3:0]];
		else if (sh_in[4:0] == `MGMT_INT_STAT_REG)
			rd_word[`MGMT_INT_STAT_BIT] = pend_m;
		else if (page_q == `MGMT_REG_RESET)
			rd_word = std_q[sh_in[4:0]];
		else
			rd_word = ext_q[sh_in[4:0]];
	end

	// Frame sequencer
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q + 5'h01;
		sh_d = sh_in;
		rd_d = rd_q;
		reg_d = reg_q;
		out_d = out_q;
		oe_d = oe_q;
		do_read = 1'b0;
		do_write = 1'b0;
		unique case (st_q)
			mgmt_serial_pkg::st_hunt:
			begin
				if (link.mdio)
					st_d = mgmt_serial_pkg::st_pre;
			end
			mgmt_serial_pkg::st_pre:
			begin
				if (!link.mdio)
					st_d = mgmt_serial_pkg::st_start;
			end
			mgmt_serial_pkg::st_start:
			begin
				cnt_d = link.mdio ? 5'h00 : skip_from(2);
				st_d = link.mdio ? mgmt_serial_pkg::st_op : mgmt_serial_pkg::st_skip;
			end
			mgmt_serial_pkg::st_op:
			begin
				if (cnt_q == 5'h01)
				begin
					cnt_d = 5'h00;
					rd_d = (sh_in[1:0] == `MGMT_OP_READ);
					if (sh_in[1:0] == `MGMT_OP_READ || sh_in[1:0] == `MGMT_OP_WRITE)
						st_d = mgmt_serial_pkg::st_phy;
					else
					begin
						cnt_d = skip_from(4);
						st_d = mgmt_serial_pkg::st_skip;
					end
				end
			end
			mgmt_serial_pkg::st_phy:
			begin
				if (cnt_q == 5'h04)
				begin
					cnt_d = 5'h00;
					if (sh_in[4:0] == addr_m)
						st_d = mgmt_serial_pkg::st_reg;
					else
					begin
						cnt_d = skip_from(9);
						st_d = mgmt_serial_pkg::st_skip;
					end
				end
			end
			mgmt_serial_pkg::st_reg:
			begin
				if (cnt_q == 5'h04)
				begin
					cnt_d = 5'h00;
					reg_d = sh_in[4:0];
					st_d = mgmt_serial_pkg::st_turn;
					if (rd_q)
					begin
						sh_d = rd_word;
						do_read = 1'b1;
					end
				end
			end
			mgmt_serial_pkg::st_turn:
			begin
				// First turnaround bit stays undriven, then drive zero
				sh_d = sh_q;
				if (cnt_q == 5'h00)
				begin
					oe_d = rd_q;
					out_d = 1'b0;
				end
				else
				begin
					cnt_d = 5'h00;
					st_d = mgmt_serial_pkg::st_data;
					if (rd_q)
					begin
						out_d = sh_q[15];
						sh_d = {sh_q[14:0], 1'b0};
					end
				end
			end
			mgmt_serial_pkg::st_data:
			begin
				if (rd_q)
				begin
					out_d = sh_q[15];
					sh_d = {sh_q[14:0], 1'b0};
				end
				if (cnt_q == 5'h0f)
				begin
					oe_d = 1'b0;
					out_d = 1'b0;
					do_write = !rd_q;
					st_d = mgmt_serial_pkg::st_hunt;
				end
			end
			mgmt_serial_pkg::st_skip:
			begin
				cnt_d = cnt_q - 5'h01;
				if (cnt_q == 5'h00)
					st_d = mgmt_serial_pkg::st_hunt;
			end
			default:
			begin
				oe_d = 1'b0;
				st_d = mgmt_serial_pkg::st_hunt;
			end
		endcase
	end

	always_ff @(posedge link.mdc)
	begin
		if (!rst_m_n)
		begin
			st_q <= mgmt_serial_pkg::st_hunt;
			cnt_q <= 5'h00;
			sh_q <= 16'h0000;
			rd_q <= 1'b0;
			reg_q <= 5'h00;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else if (en_m)
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			reg_q <= reg_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// Register side effects of reads once the register field is in, and of completed writes
	always_comb
	begin
		page_d = page_q;
		mmd_ctl_d = mmd_ctl_q;
		mmd_addr_d = mmd_addr_q;
		std_we = 1'b0;
		ext_we = 1'b0;
		mmd_we = 1'b0;
		clr_tgl_d = clr_tgl_q;
		wr_tgl_d = wr_tgl_q;
		wr_addr_d = wr_addr_q;
		wr_val_d = wr_val_q;
		if (do_read && sh_in[4:0] == `MGMT_INT_STAT_REG)
			clr_tgl_d = !clr_tgl_q;
		if (do_read && sh_in[4:0] == `MGMT_MMD_DATA_REG && mmd_ctl_q[15:14] == `MGMT_MMD_FUNC_INCR)
			mmd_addr_d = mmd_addr_q + 16'h0001;
		if (do_write)
		begin
			wr_tgl_d = !wr_tgl_q;
			wr_addr_d = reg_q;
			wr_val_d = sh_in;
			if (reg_q == `MGMT_PAGE_REG)
				page_d = sh_in;
			else if (reg_q == `MGMT_MMD_CTRL_REG)
				mmd_ctl_d = sh_in;
			else if (reg_q == `MGMT_MMD_DATA_REG)
			begin
				if (mmd_ctl_q[15:14] == `MGMT_MMD_FUNC_ADDR)
					mmd_addr_d = sh_in;
				else
					mmd_we = 1'b1;
				if (mmd_ctl_q[15:14] == `MGMT_MMD_FUNC_INCR)
					mmd_addr_d = mmd_addr_q + 16'h0001;
			end
			else if (reg_q != `MGMT_INT_STAT_REG)
			begin
				std_we = (page_q == `MGMT_REG_RESET);
				ext_we = (page_q != `MGMT_REG_RESET);
			end
		end
	end

	always_ff @(posedge link.mdc)
	begin
		if (!rst_m_n)
		begin
			for (int i = 0; i < `MGMT_REG_COUNT; i++)
			begin
				std_q[i] <= `MGMT_REG_RESET;
				ext_q[i] <= `MGMT_REG_RESET;
			end
			for (int i = 0; i < `MGMT_MMD_DEPTH; i++)
				mmd_q[i] <= `MGMT_REG_RESET;
			page_q <= `MGMT_REG_RESET;
			mmd_ctl_q <= `MGMT_REG_RESET;
			mmd_addr_q <= `MGMT_REG_RESET;
			clr_tgl_q <= 1'b0;
			wr_tgl_q <= 1'b0;
			wr_addr_q <= 5'h00;
			wr_val_q <= 16'h0000;
		end
		else if (en_m)
		begin
			if (std_we)
				std_q[reg_q] <= sh_in;
			if (ext_we)
				ext_q[reg_q] <= sh_in;
			if (mmd_we)
				mmd_q[mmd_addr_q[3:0]] <= sh_in;
			page_q <= page_d;
			mmd_ctl_q <= mmd_ctl_d;
			mmd_addr_q <= mmd_addr_d;
			clr_tgl_q <= clr_tgl_d;
			wr_tgl_q <= wr_tgl_d;
			wr_addr_q <= wr_addr_d;
			wr_val_q <= wr_val_d;
		end
	end

	// System domain: enable, clear and write toggles cross out
	logic int_en_s, clr_s, wr_s, hi_s;
	logic rst_ack_s, rst_req_d;
	logic clr_seen_q, wr_seen_q;
	logic pend_d, wr_valid_q, wr_valid_d;
	logic [4:0] wr_reg_q, wr_reg_d;
	logic [15:0] wr_data_q, wr_data_d;
	logic irq_o_q, irq_o_d, irq_oe_q, irq_oe_d;
	mgmt_sync2 #(.W(5)) u_sync_out
	(
		.clk(ref_clk),
		.d({std_q[`MGMT_INT_CTRL_REG][`MGMT_INT_EN_BIT], clr_tgl_q, wr_tgl_q, int_active_high, !rst_m_n}),
		.q({int_en_s, clr_s, wr_s, hi_s, rst_ack_s})
	);

	always_comb
	begin
		// Drop the link reset request only once the link side reports it is in reset
		rst_req_d = rst_req_q;
		if (rst_ack_s)
			rst_req_d = 1'b0;
		pend_d = pend_q;
		if (clr_s != clr_seen_q)
			pend_d = 1'b0;
		// A new event beats a clear in the same cycle
		if (phy_event)
			pend_d = 1'b1;
		wr_valid_d = (wr_s != wr_seen_q);
		wr_reg_d = wr_valid_d ? wr_addr_q : wr_reg_q;
		wr_data_d = wr_valid_d ? wr_val_q : wr_data_q;
		irq_oe_d = pend_q && int_en_s;
		irq_o_d = hi_s;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rst_req_q <= 1'b1;
			pend_q <= 1'b0;
			clr_seen_q <= 1'b0;
			wr_seen_q <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_reg_q <= 5'h00;
			wr_data_q <= 16'h0000;
			irq_o_q <= 1'b0;
			irq_oe_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rst_req_q <= rst_req_d;
			pend_q <= pend_d;
			clr_seen_q <= clr_s;
			wr_seen_q <= wr_s;
			wr_valid_q <= wr_valid_d;
			wr_reg_q <= wr_reg_d;
			wr_data_q <= wr_data_d;
			irq_o_q <= irq_o_d;
			irq_oe_q <= irq_oe_d;
		end
	end

	assign wr_valid = wr_valid_q;
	assign wr_reg = wr_reg_q;
	assign wr_data = wr_data_q;
	assign mgmt_interrupt_out_o = irq_o_q;
	assign mgmt_interrupt_out_oe = irq_oe_q;
endmodule

/* File: hw/mgmt_station.sv */
// Station manager end: builds frames, divides ref_clk into mdc.
// Assumes a single slave shares the link through the interface.
`timescale 1ns/100ps
`include "mgmt_serial_params.svh"
module mgmt_station
(
	// Link
	mgmt_serial_if.host link,
	// Clock and control
	input logic ref_clk,
	input logic rst_n,
	input logic clk_en,
	// Command
	input logic cmd_valid,
	output logic cmd_ready,
	input logic cmd_write,
	input logic [4:0] cmd_phy,
	input logic [4:0] cmd_reg,
	input logic [15:0] cmd_wdata,
	// Response
	output logic resp_valid,
	output logic [15:0] resp_rdata
);
	localparam logic [2:0] HALF_LAST = 3'(`MGMT_MDC_HALF_CYCLES - 1);
	localparam logic [5:0] POS_LAST = 6'(`MGMT_PREAMBLE_BITS + `MGMT_FRAME_BITS - 1);
	localparam logic [5:0] POS_DATA = 6'(`MGMT_PREAMBLE_BITS + `MGMT_FRAME_BITS - `MGMT_DATA_BITS);

	// Returns {enable, level} for the bit at a position of preamble plus frame
	function automatic logic [1:0] drive_bit(input logic [5:0] pos, input logic [31:0] frame, input logic wr);
		logic [5:0] idx;
		idx = POS_LAST - pos;
		if (pos < 6'(`MGMT_PREAMBLE_BITS))
			return 2'h3;
		// Reads let go from the first turnaround bit onward
		return {wr || idx >= 6'h12, frame[idx[4:0]]};
	endfunction

	logic mdio_s;
	mgmt_sync2 #(.W(1)) u_sync_mdio
	(
		.clk(ref_clk),
		.d(link.mdio),
		.q(mdio_s)
	);

	mgmt_serial_pkg::host_state_t st_q, st_d;
	logic [2:0] div_q, div_d;
	logic mdc_q, mdc_d;
	logic [5:0] pos_q, pos_d;
	logic [31:0] frame_q, frame_d;
	logic wr_q, wr_d;
	logic o_q, o_d, oe_q, oe_d;
	logic [15:0] rdat_q, rdat_d;
	logic resp_q, resp_d;
	logic tick;
	logic [31:0] frame_new;
	logic [1:0] bit_new;
	logic [1:0] bit_next;

	assign tick = (div_q == 3'h0);
	assign frame_new = {`MGMT_START_PATTERN, cmd_write ? `MGMT_OP_WRITE : `MGMT_OP_READ, cmd_phy, cmd_reg,
		`MGMT_TURN_WRITE, cmd_write ? cmd_wdata : 16'h0000};
	assign bit_new = drive_bit(6'h00, frame_new, cmd_write);
	assign bit_next = drive_bit(pos_q + 6'h01, frame_q, wr_q);
	assign cmd_ready = (st_q == mgmt_serial_pkg::hs_idle);

	always_comb
	begin
		st_d = st_q;
		div_d = tick ? HALF_LAST : div_q - 3'h1;
		mdc_d = mdc_q;
		pos_d = pos_q;
		frame_d = frame_q;
		wr_d = wr_q;
		o_d = o_q;
		oe_d = oe_q;
		rdat_d = rdat_q;
		resp_d = 1'b0;
		unique case (st_q)
			mgmt_serial_pkg::hs_idle:
			begin
				div_d = HALF_LAST;
				if (cmd_valid)
				begin
					st_d = mgmt_serial_pkg::hs_run;
					pos_d = 6'h00;
					frame_d = frame_new;
					wr_d = cmd_write;
					{oe_d, o_d} = bit_new;
				end
			end
			mgmt_serial_pkg::hs_run:
			begin
				if (tick)
				begin
					mdc_d = !mdc_q;
					if (!mdc_q)
					begin
						// Rising edge: slave samples, station captures read data
						if (!wr_q && pos_q >= POS_DATA)
							rdat_d = {rdat_q[14:0], mdio_s};
						if (pos_q == POS_LAST)
							st_d = mgmt_serial_pkg::hs_tail;
					end
					else
					begin
						pos_d = pos_q + 6'h01;
						{oe_d, o_d} = bit_next;
					end
				end
			end
			mgmt_serial_pkg::hs_tail:
			begin
				if (tick)
				begin
					mdc_d = 1'b0;
					oe_d = 1'b0;
					o_d = 1'b0;
					resp_d = 1'b1;
					st_d = mgmt_serial_pkg::hs_idle;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			st_q <= mgmt_serial_pkg::hs_idle;
			div_q <= HALF_LAST;
			mdc_q <= 1'b0;
			pos_q <= 6'h00;
			frame_q <= 32'h00000000;
			wr_q <= 1'b0;
			o_q <= 1'b0;
			oe_q <= 1'b0;
			rdat_q <= 16'h0000;
			resp_q <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			div_q <= div_d;
			mdc_q <= mdc_d;
			pos_q <= pos_d;
			frame_q <= frame_d;
			wr_q <= wr_d;
			o_q <= o_d;
			oe_q <= oe_d;
			rdat_q <= rdat_d;
			resp_q <= resp_d;
		end
	end

	assign link.mdc = mdc_q;
	assign link.host_mdio_o = o_q;
	assign link.host_mdio_oe = oe_q;
	assign resp_valid = resp_q;
	assign resp_rdata = rdat_q;
endmodule

/* File: hw/mgmt_sync2.sv */
// Two-stage synchroniser for levels and toggles.
// Assumes the input is stable long enough for the destination clock.
`timescale 1ns/100ps
module mgmt_sync2 #(
	parameter int W = 1
)
(
	// Destination clock
	input logic clk,
	// Data
	input logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// No reset or enable: must keep passing reset and enable themselves
	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule

/* File: inc/mgmt_serial_if.sv */
// Interface joining the station and the slave on the serial link.
// Resolves the shared data line; an idle line reads as one (pull-up).
`timescale 1ns/100ps
interface mgmt_serial_if;
	logic mdc;
	logic mdio;
	logic dev_mdio_o;
	logic dev_mdio_oe;
	logic host_mdio_o;
	logic host_mdio_oe;

	assign mdio = dev_mdio_oe ? dev_mdio_o : (host_mdio_oe ? host_mdio_o : 1'b1);

	modport device (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
	modport host (output mdc, input mdio, output host_mdio_o, output host_mdio_oe);
endinterface

/* File: inc/mgmt_serial_params.svh */
// Constants shared by both ends of the management serial link.
// Assumes inclusion by bare name from files that use the values.
`ifndef MGMT_SERIAL_PARAMS_SVH
`define MGMT_SERIAL_PARAMS_SVH

// Frame layout
`define MGMT_FRAME_BITS 32
`define MGMT_DATA_BITS 16
`define MGMT_START_PATTERN 2'h1
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_TURN_WRITE 2'h2
`define MGMT_PREAMBLE_BITS 32

// Register map
`define MGMT_REG_COUNT 32
`define MGMT_MMD_DEPTH 16
`define MGMT_MMD_CTRL_REG 5'h0d
`define MGMT_MMD_DATA_REG 5'h0e
`define MGMT_INT_CTRL_REG 5'h19
`define MGMT_INT_STAT_REG 5'h1a
`define MGMT_PAGE_REG 5'h1f
`define MGMT_INT_EN_BIT 15
`define MGMT_INT_STAT_BIT 15
`define MGMT_MMD_FUNC_ADDR 2'h0
`define MGMT_MMD_FUNC_INCR 2'h2
`define MGMT_REG_RESET 16'h0000

// Timing
`define MGMT_REF_CLK_PERIOD_NS 10
`define MGMT_MDC_MAX_KHZ 12500
`define MGMT_MDC_MIN_PERIOD_NS (1000000 / `MGMT_MDC_MAX_KHZ)
`define MGMT_MDC_HALF_CYCLES \
	((`MGMT_MDC_MIN_PERIOD_NS + 2 * `MGMT_REF_CLK_PERIOD_NS - 1) / (2 * `MGMT_REF_CLK_PERIOD_NS))

`endif

/* File: inc/mgmt_serial_pkg.sv */
// Types shared by both ends of the management serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package mgmt_serial_pkg;

	typedef enum logic [8:0]
	{
		st_hunt = 9'h001,
		st_pre = 9'h002,
		st_start = 9'h004,
		st_op = 9'h008,
		st_phy = 9'h010,
		st_reg = 9'h020,
		st_turn = 9'h040,
		st_data = 9'h080,
		st_skip = 9'h100
	} dev_state_t;

	typedef enum logic [2:0]
	{
		hs_idle = 3'h1,
		hs_run = 3'h2,
		hs_tail = 3'h4
	} host_state_t;

	typedef logic [15:0] reg_word_t;

endpackage

/* File: sim/phy_mgmt_serial_properties.sv */
// Checker on the shared link between the station and the slave.
// Assumes mdc is divided from ref_clk, so the two clocks share edges.
`timescale 1ns/100ps
module phy_mgmt_serial_properties
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link wires
	input wire logic mdc,
	input wire logic mdio,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe,
	input wire logic host_mdio_o,
	input wire logic host_mdio_oe
);
	logic [4:0] drive_cnt_q;
	logic [4:0] drive_cnt_d;

	// Link clock stops after a frame, so the length is judged at the next frame
	always_comb
	begin
		drive_cnt_d = (rst_n && dev_mdio_oe) ? drive_cnt_q + 5'h01 : 5'h00;
	end

	always_ff @(posedge mdc)
	begin
		drive_cnt_q <= drive_cnt_d;
	end

	sequence s_read_head;
		$past(mdio, 15) == 1'b0 && $past(mdio, 14) && $past(mdio, 13) && $past(mdio, 12) == 1'b0;
	endsequence

	sequence s_turn_then_data;
		(!mdio && !dev_mdio_o) ##1 dev_mdio_oe [*8] ##1 dev_mdio_oe [*8];
	endsequence

	a_no_line_clash: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(dev_mdio_oe && host_mdio_oe)) else $error("both ends drive the line");
	a_read_frame_head: assert property (@(posedge mdc) disable iff (!rst_n)
		$rose(dev_mdio_oe) |-> s_read_head) else $error("drive without start and read code");
	a_turn_drive_zero: assert property (@(posedge mdc) disable iff (!rst_n)
		$rose(dev_mdio_oe) |-> s_turn_then_data) else $error("turnaround or data drive wrong");
	a_first_turn_free: assert property (@(posedge mdc) disable iff (!rst_n)
		$rose(dev_mdio_oe) |-> $past(mdio) && !$past(host_mdio_oe)) else $error("first turnaround not free");
	a_read_bit_count: assert property (@(posedge mdc) disable iff (!rst_n)
		dev_mdio_oe ##1 !dev_mdio_oe |-> drive_cnt_q == 5'h11) else $error("drive length not 17 bits");
	a_launch_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dev_mdio_oe && $changed(dev_mdio_o) |-> $rose(mdc)) else $error("read bit moved off a rising edge");
	a_idle_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!mdc [*8] |-> !dev_mdio_oe) else $error("slave drives an idle line");
	a_host_data_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
		host_mdio_oe && $changed(host_mdio_o) |-> !mdc [*3]) else $error("write bit moved near a rising edge");
	a_mdc_high_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(mdc) |-> mdc [*4]) else $error("link clock high too short");
	a_mdc_low_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(mdc) |-> !mdc [*4]) else $error("link clock low too short");
endmodule

/* File: sim/phy_mgmt_serial_slave_bench.sv */
// Bench: station and slave on one link, a second slave fed by a rule-breaking driver.
// Assumes the station's 4-cycle half period; the second link clock is made here at 12 ns.
`timescale 1ns/100ps
`define CHECK(nm, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			n_errors++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module phy_mgmt_serial_slave_bench;
	localparam logic [4:0] own_phy = 5'h11;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [4:0] phy_addr = own_phy;
	logic int_active_high = 1'b0;
	logic phy_event = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [4:0] cmd_phy = 5'h00;
	logic [4:0] cmd_reg = 5'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic cmd_ready, resp_valid, wr_valid, wr_valid_b, irq_o, irq_oe;
	logic [15:0] resp_rdata, wr_data, wr_data_b;
	logic [4:0] wr_reg, wr_reg_b;
	logic [63:0] wire_q = 64'h0;
	int n_errors = 0;
	int comparisons = 0;
	int n_wr = 0;
	int n_wr_b = 0;

	mgmt_serial_if link ();
	mgmt_serial_if link_b ();

	always #5 ref_clk = ~ref_clk;

	mgmt_station i_mgmt_station (.link(link.host), .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_phy(cmd_phy),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata));
	mgmt_frame_slave i_mgmt_frame_slave (.link(link.device), .ref_clk(ref_clk), .rst_n(rst_n),
		.clk_en(clk_en), .phy_addr(phy_addr), .int_active_high(int_active_high), .phy_event(phy_event),
		.wr_valid(wr_valid), .wr_reg(wr_reg), .wr_data(wr_data), .mgmt_interrupt_out_o(irq_o),
		.mgmt_interrupt_out_oe(irq_oe));
	mgmt_frame_slave i_mgmt_frame_slave_b (.link(link_b.device), .ref_clk(ref_clk), .rst_n(rst_n),
		.clk_en(clk_en), .phy_addr(phy_addr), .int_active_high(int_active_high), .phy_event(phy_event),
		.wr_valid(wr_valid_b), .wr_reg(wr_reg_b), .wr_data(wr_data_b), .mgmt_interrupt_out_o(),
		.mgmt_interrupt_out_oe());
	phy_mgmt_serial_properties i_phy_mgmt_serial_properties (.ref_clk(ref_clk), .rst_n(rst_n),
		.mdc(link.mdc), .mdio(link.mdio), .dev_mdio_o(link.dev_mdio_o), .dev_mdio_oe(link.dev_mdio_oe),
		.host_mdio_o(link.host_mdio_o), .host_mdio_oe(link.host_mdio_oe));

	always @(posedge ref_clk)
	begin
		if (wr_valid === 1'b1)
			n_wr++;
		if (wr_valid_b === 1'b1)
			n_wr_b++;
	end

	always @(posedge link.mdc)
		wire_q <= {wire_q[62:0], link.mdio};

	task automatic xfer(input logic w, input logic [4:0] p, input logic [4:0] r, input logic [15:0] d,
		output logic [15:0] q);
		int t;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_phy = p;
		cmd_reg = r;
		cmd_wdata = d;
		for (t = 0; t < 99 && cmd_ready !== 1'b1; t++)
			@(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		for (t = 0; t < 999 && resp_valid !== 1'b1; t++)
			@(negedge ref_clk);
		`CHECK("resp_valid", 1'b1, resp_valid)
		q = resp_rdata;
	endtask

	task automatic wr(input logic [4:0] r, input logic [15:0] d, input logic [4:0] p = own_phy);
		logic [15:0] q;
		xfer(1'b1, p, r, d, q);
	endtask

	task automatic rd(input logic [4:0] r, input logic [15:0] e, input logic [4:0] p = own_phy);
		logic [15:0] q;
		xfer(1'b0, p, r, 16'h0000, q);
		`CHECK("read data", e, q)
	endtask

	// Covers the crossing of write notices and interrupt state into ref_clk
	task automatic settle();
		repeat (16) @(negedge ref_clk);
	endtask

	task automatic pulse_event();
		@(negedge ref_clk);
		phy_event = 1'b1;
		@(negedge ref_clk);
		phy_event = 1'b0;
		settle();
	endtask

	// Second link: bits change while the clock is low, the clock rests low between frames
	task automatic send_bits(input logic [31:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			link_b.host_mdio_o = bits[i];
			link_b.host_mdio_oe = 1'b1;
			#6 link_b.mdc = 1'b1;
			#6 link_b.mdc = 1'b0;
		end
		link_b.host_mdio_oe = 1'b0;
		// Let time pass so a following call never re-drives the enable in the same step
		#6;
	endtask

	function automatic logic [31:0] frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] r,
		input logic [15:0] d);
		return {st, op, own_phy, r, 2'h2, d};
	endfunction

	task automatic t_write_read();
		int base;
		base = n_wr;
		wr(5'h00, 16'ha55a);
		wr(5'h1e, 16'h3cc3);
		settle();
		`CHECK("write count", base + 2, n_wr)
		`CHECK("write reg", 5'h1e, wr_reg)
		`CHECK("write data", 16'h3cc3, wr_data)
		rd(5'h00, 16'ha55a);
		rd(5'h1e, 16'h3cc3);
		`CHECK("wire frame", {32'hffffffff, 2'h1, 2'h2, own_phy, 5'h1e, 2'h2, 16'h3cc3}, wire_q)
		$display("test write_read done");
	endtask

	task automatic t_foreign();
		int base;
		base = n_wr;
		wr(5'h00, 16'h0f0f, 5'h10);
		settle();
		`CHECK("foreign write count", base, n_wr)
		rd(5'h00, 16'hffff, 5'h10);
		rd(5'h00, 16'ha55a);
		$display("test foreign done");
	endtask

	task automatic t_paging();
		wr(5'h1f, 16'h0001);
		wr(5'h03, 16'h7e57);
		rd(5'h1f, 16'h0001);
		wr(5'h1f, 16'h0000);
		rd(5'h03, 16'h0000);
		wr(5'h1f, 16'h0002);
		rd(5'h03, 16'h7e57);
		wr(5'h1f, 16'h0000);
		$display("test paging done");
	endtask

	task automatic t_indirect();
		wr(5'h0d, 16'h0000);
		wr(5'h0e, 16'h0005);
		wr(5'h0d, 16'h8000);
		wr(5'h0e, 16'h1111);
		wr(5'h0e, 16'h2222);
		for (int i = 0; i < 2; i++)
		begin
			wr(5'h0d, 16'h0000);
			wr(5'h0e, 16'h0005 + 16'(i));
			wr(5'h0d, 16'h4000);
			rd(5'h0e, (i == 0) ? 16'h1111 : 16'h2222);
		end
		$display("test indirect done");
	endtask

	task automatic t_interrupt();
		wr(5'h19, 16'h0000);
		pulse_event();
		`CHECK("irq masked", 1'b0, irq_oe)
		wr(5'h19, 16'h8000);
		settle();
		`CHECK("irq enabled", 1'b1, irq_oe)
		`CHECK("irq level low", 1'b0, irq_o)
		rd(5'h1a, 16'h8000);
		settle();
		`CHECK("irq cleared", 1'b0, irq_oe)
		rd(5'h1a, 16'h0000);
		int_active_high = 1'b1;
		pulse_event();
		`CHECK("irq level high", 1'b1, irq_o)
		`CHECK("irq raised", 1'b1, irq_oe)
		$display("test interrupt done");
	endtask

	task automatic t_bad_frames();
		int base;
		base = n_wr_b;
		send_bits(32'hffffffff, 32);
		send_bits(frame(2'h0, 2'h1, 5'h02, 16'h1234), 32);
		for (int i = 0; i < 2; i++)
		begin
			send_bits(32'h1, 1);
			send_bits(frame(2'h1, 2'(3 * i), 5'h02, 16'h1234), 32);
		end
		settle();
		`CHECK("bad frame writes", base, n_wr_b)
		send_bits(32'h1, 1);
		send_bits(frame(2'h1, 2'h1, 5'h07, 16'hc0de), 32);
		settle();
		`CHECK("good write count", base + 1, n_wr_b)
		`CHECK("good write reg", 5'h07, wr_reg_b)
		`CHECK("good write data", 16'hc0de, wr_data_b)
		$display("test bad_frames done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// About 32 frames of some 520 cycles each are expected
	initial
	begin
		#400000;
		n_errors++;
		$display("Error watchdog expected done seen hang");
		finish_test();
	end

	initial
	begin
		link_b.mdc = 1'b0;
		fork
			repeat (10) @(negedge ref_clk);
			send_bits(32'hffffffff, 8);
		join
		rst_n = 1'b1;
		t_write_read();
		t_foreign();
		t_paging();
		t_indirect();
		t_interrupt();
		t_bad_frames();
		finish_test();
	end
endmodule
